// ==== adc_pwr_pkg.sv ====
// Shared constants and types for the converter power and conversion sequencer
package adc_pwr_pkg;
	localparam int          CLK_MHZ          = 200;
	localparam int          CONV_TIME_NS     = 2300;
	localparam int          WAKE_TIME_NS     = 1000;
	localparam int          REF_UP_TIME_US   = 30;
	localparam int          ACQ_GAP_NS       = 100;
	localparam int          CONV_CYCLES      = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int          WAKE_CYCLES      = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int          REF_UP_CYCLES    = REF_UP_TIME_US * CLK_MHZ;
	localparam int          ACQ_GAP_CYCLES   = (ACQ_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int          RESULT_W         = 10;
	localparam int          CNT_W            = 16;
	localparam int          SCLK_DIV         = 8;
	localparam logic [1:0]  PSEL_FULL_UP     = 2'h3;
	localparam logic [1:0]  PSEL_FULL_DOWN   = 2'h0;
	localparam logic [1:0]  PSEL_AUTO_PART   = 2'h1;
	localparam logic [1:0]  PSEL_AUTO_FULL   = 2'h2;
	localparam logic [1:0]  PSEL_RESET       = 2'h0;

	typedef enum logic [2:0] {
		PS_OFF     = 3'h0,
		PS_WAKE    = 3'h1,
		PS_IDLE    = 3'h2,
		PS_CONV    = 3'h3,
		PS_ASLEEP  = 3'h4
	} pwr_state_t;

	typedef enum logic [1:0] {
		HS_IDLE    = 2'h0,
		HS_LOW     = 2'h1,
		HS_WAIT    = 2'h2,
		HS_READ    = 2'h3
	} host_state_t;
endpackage

// ==== adc_link_if.sv ====
// Link between the converter sequencer and its host controller
`timescale 1ns/10ps
interface adc_link_if;
	logic                conv_start_n;
	logic                rx_frame_sync;
	logic                sclk;
	logic                dout;
	logic                dout_oe;
	logic [1:0]          power_sel;
	logic                ext_ref_sel;
	logic                power_sel_wr;

	modport device (
		input  conv_start_n,
		input  rx_frame_sync,
		input  sclk,
		input  power_sel,
		input  ext_ref_sel,
		input  power_sel_wr,
		output dout,
		output dout_oe
	);
	modport host (
		output conv_start_n,
		output rx_frame_sync,
		output sclk,
		output power_sel,
		output ext_ref_sel,
		output power_sel_wr,
		input  dout,
		input  dout_oe
	);
endinterface

// ==== adc_pwr_seq.sv ====
// Device end: power states, conversion timing and result shift-out
`timescale 1ns/10ps
module adc_pwr_seq
	import adc_pwr_pkg::*;
#(
	parameter int REF_CYCLES = REF_UP_CYCLES
) (
	input  wire logic                clk_sys_in,
	input  wire logic                reset_in,
	adc_link_if.device               link,
	input  wire logic [RESULT_W-1:0] sample_in,
	output logic                     powered_out,
	output logic                     ref_powered_out,
	output logic                     converting_out,
	output logic [RESULT_W-1:0]      result_out
);
	logic [1:0]           cs_sync_reg, fs_sync_reg, ck_sync_reg;
	logic [1:0]           cs_sync_next, fs_sync_next, ck_sync_next;
	logic                 cs_prev_reg, fs_prev_reg, ck_prev_reg;
	pwr_state_t           state_reg, state_next;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	logic                 ref_up_reg, ref_up_next;
	logic                 ref_ok_reg, ref_ok_next;
	logic                 pend_conv_reg, pend_conv_next;
	logic [1:0]           psel_reg, psel_next;
	logic                 ext_ref_sel_reg, ext_ref_sel_next;
	logic [RESULT_W-1:0]  result_reg, result_next;
	logic                 load_pend_reg, load_pend_next;
	logic [RESULT_W-1:0]  shift_reg, shift_next;
	logic                 armed_reg, armed_next;
	logic                 active_reg, active_next;
	logic [3:0]           bit_cnt_reg, bit_cnt_next;
	logic                 dout_reg, dout_next;
	logic                 oe_reg, oe_next;
	logic                 cs_now, cs_rise, cs_fall, fs_rise, ck_rise, load_now;

	assign cs_now  = cs_sync_reg[1];
	assign cs_rise = cs_now & ~cs_prev_reg;
	assign cs_fall = ~cs_now & cs_prev_reg;
	assign fs_rise = fs_sync_reg[1] & ~fs_prev_reg;
	assign ck_rise = ck_sync_reg[1] & ~ck_prev_reg;
	// A load on the first sclk rise would be overwritten by the shift and lost
	assign load_now = load_pend_reg && !active_reg && !(ck_rise && armed_reg);

	always_comb begin
		cs_sync_next = {cs_sync_reg[0], link.conv_start_n};
		fs_sync_next = {fs_sync_reg[0], link.rx_frame_sync};
		ck_sync_next = {ck_sync_reg[0], link.sclk};
	end

	// Power and conversion sequencing
	always_comb begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		ref_up_next    = ref_up_reg;
		ref_ok_next    = ref_ok_reg;
		pend_conv_next = pend_conv_reg;
		psel_next      = psel_reg;
		ext_ref_sel_next    = ext_ref_sel_reg;
		result_next    = result_reg;
		load_pend_next = load_pend_reg;
		if (link.power_sel_wr) begin
			psel_next   = link.power_sel;
			ext_ref_sel_next = link.ext_ref_sel;
		end
		// Clear first so that a conversion ending in the same cycle re-arms the load
		if (load_now)
			load_pend_next = 1'b0;
		unique case (state_reg)
			PS_OFF: begin
				// Full power-down drops the reference; a long sleep must re-warm it
				ref_ok_next = 1'b0;
				if (psel_reg == PSEL_FULL_UP) begin
					state_next  = PS_WAKE;
					cnt_next    = '0;
					ref_up_next = 1'b0;
				end
			end
			PS_WAKE: begin
				cnt_next = cnt_reg + 1'b1;
				if (cs_fall)
					pend_conv_next = 1'b1;
				// External reference or a warm reference needs only the short wake
				if ((ext_ref_sel_reg || ref_ok_reg) && cnt_reg >= CNT_W'(WAKE_CYCLES - 1)) begin
					ref_up_next = 1'b1;
				end else if (cnt_reg >= CNT_W'(REF_CYCLES - 1)) begin
					ref_up_next = 1'b1;
					ref_ok_next = 1'b1;
				end
				if (ref_up_reg) begin
					cnt_next       = '0;
					pend_conv_next = 1'b0;
					state_next     = (pend_conv_reg || cs_fall) ? PS_CONV : PS_IDLE;
				end
			end
			PS_IDLE: begin
				if (psel_reg == PSEL_FULL_DOWN)
					state_next = PS_OFF;
				else if (cs_fall) begin
					state_next = PS_CONV;
					cnt_next   = '0;
				end
			end
			PS_CONV: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
					cnt_next       = '0;
					load_pend_next = 1'b1;
					result_next    = sample_in;
					state_next     = PS_IDLE;
					if (!cs_now && psel_reg == PSEL_AUTO_FULL) begin
						state_next  = PS_ASLEEP;
						ref_ok_next = ~ext_ref_sel_reg;
					end else if (!cs_now && psel_reg == PSEL_AUTO_PART) begin
						state_next  = PS_ASLEEP;
						ref_ok_next = 1'b1;
					end else if (psel_reg == PSEL_FULL_DOWN) begin
						state_next = PS_OFF;
					end
				end
			end
			PS_ASLEEP: begin
				if (psel_reg == PSEL_FULL_DOWN)
					state_next = PS_OFF;
				else if (psel_reg == PSEL_FULL_UP || cs_rise) begin
					state_next  = PS_WAKE;
					cnt_next    = '0;
					ref_up_next = 1'b0;
				end
			end
			default: state_next = PS_OFF;
		endcase
	end

	// Serial shift-out keeps running in every power state
	always_comb begin
		shift_next   = shift_reg;
		armed_next   = armed_reg;
		active_next  = active_reg;
		bit_cnt_next = bit_cnt_reg;
		dout_next    = dout_reg;
		oe_next      = oe_reg;
		if (load_now)
			shift_next = result_reg;
		if (fs_rise) begin
			armed_next  = 1'b1;
			active_next = 1'b0;
			oe_next     = 1'b0;
		end else if (ck_rise && armed_reg) begin
			armed_next   = 1'b0;
			active_next  = 1'b1;
			oe_next      = 1'b1;
			dout_next    = shift_reg[RESULT_W-1];
			shift_next   = {shift_reg[RESULT_W-2:0], 1'b0};
			bit_cnt_next = 4'h1;
		end else if (ck_rise && active_reg) begin
			if (bit_cnt_reg == 4'(RESULT_W)) begin
				// Tristate on the eleventh edge; result restored for a re-read
				active_next = 1'b0;
				oe_next     = 1'b0;
				shift_next  = result_reg;
			end else begin
				dout_next    = shift_reg[RESULT_W-1];
				shift_next   = {shift_reg[RESULT_W-2:0], 1'b0};
				bit_cnt_next = bit_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			cs_sync_reg   <= 2'h3;
			fs_sync_reg   <= 2'h0;
			ck_sync_reg   <= 2'h0;
			cs_prev_reg   <= 1'b1;
			fs_prev_reg   <= 1'b0;
			ck_prev_reg   <= 1'b0;
			state_reg     <= PS_OFF;
			cnt_reg       <= '0;
			ref_up_reg    <= 1'b0;
			ref_ok_reg    <= 1'b0;
			pend_conv_reg <= 1'b0;
			psel_reg      <= PSEL_RESET;
			ext_ref_sel_reg    <= 1'b0;
			result_reg    <= '0;
			load_pend_reg <= 1'b0;
			shift_reg     <= '0;
			armed_reg     <= 1'b0;
			active_reg    <= 1'b0;
			bit_cnt_reg   <= 4'h0;
			dout_reg      <= 1'b0;
			oe_reg        <= 1'b0;
		end else begin
			cs_sync_reg   <= cs_sync_next;
			fs_sync_reg   <= fs_sync_next;
			ck_sync_reg   <= ck_sync_next;
			cs_prev_reg   <= cs_sync_reg[1];
			fs_prev_reg   <= fs_sync_reg[1];
			ck_prev_reg   <= ck_sync_reg[1];
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			ref_up_reg    <= ref_up_next;
			ref_ok_reg    <= ref_ok_next;
			pend_conv_reg <= pend_conv_next;
			psel_reg      <= psel_next;
			ext_ref_sel_reg    <= ext_ref_sel_next;
			result_reg    <= result_next;
			load_pend_reg <= load_pend_next;
			shift_reg     <= shift_next;
			armed_reg     <= armed_next;
			active_reg    <= active_next;
			bit_cnt_reg   <= bit_cnt_next;
			dout_reg      <= dout_next;
			oe_reg        <= oe_next;
		end
	end

	assign link.dout    = dout_reg;
	assign link.dout_oe = oe_reg;

	logic                pwr_out_reg, refp_out_reg, conv_out_reg;
	logic [RESULT_W-1:0] res_out_reg;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			pwr_out_reg  <= 1'b0;
			refp_out_reg <= 1'b0;
			conv_out_reg <= 1'b0;
			res_out_reg  <= '0;
		end else begin
			pwr_out_reg  <= (state_next == PS_IDLE) || (state_next == PS_CONV);
			refp_out_reg <= (state_next != PS_OFF) && !ext_ref_sel_next
				&& !(state_next == PS_ASLEEP && psel_next == PSEL_AUTO_FULL);
			conv_out_reg <= (state_next == PS_CONV);
			res_out_reg  <= result_next;
		end
	end
	assign powered_out     = pwr_out_reg;
	assign ref_powered_out = refp_out_reg;
	assign converting_out  = conv_out_reg;
	assign result_out      = res_out_reg;
endmodule

// ==== adc_host_ctrl.sv ====
// Host end: drives start pin, power field and serial reads
`timescale 1ns/10ps
module adc_host_ctrl
	import adc_pwr_pkg::*;
(
	input  wire logic                clk_sys_in,
	input  wire logic                reset_in,
	adc_link_if.host                 link,
	input  wire logic [1:0]          power_sel_in,
	input  wire logic                ext_ref_sel_in,
	input  wire logic                power_wr_in,
	input  wire logic                convert_in,
	input  wire logic                stay_up_in,
	output logic                     busy_out,
	output logic                     data_valid_out,
	output logic [RESULT_W-1:0]      data_out
);
	host_state_t          st_reg, st_next;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	logic [3:0]           div_reg, div_next;
	logic [4:0]           edge_reg, edge_next;
	logic                 cs_reg, cs_next, fs_reg, fs_next, ck_reg, ck_next;
	logic [1:0]           ps_reg, ps_next;
	logic                 er_reg, er_next, wr_reg, wr_next;
	logic [RESULT_W-1:0]  sh_reg, sh_next, dat_reg, dat_next;
	logic                 dv_reg, dv_next, up_reg, up_next;
	logic [1:0]           din_sync_reg;
	logic                 tick;
	logic                 busy_reg;

	assign tick = (div_reg == 4'(SCLK_DIV - 1));

	always_comb begin
		st_next = st_reg;  cnt_next = cnt_reg;  edge_next = edge_reg;
		cs_next = cs_reg;  fs_next = fs_reg;    ck_next = ck_reg;
		sh_next = sh_reg;  dat_next = dat_reg;  dv_next = 1'b0;
		up_next = up_reg;
		div_next = tick ? 4'h0 : div_reg + 4'h1;
		ps_next = power_wr_in ? power_sel_in : ps_reg;
		er_next = power_wr_in ? ext_ref_sel_in : er_reg;
		wr_next = power_wr_in;
		unique case (st_reg)
			HS_IDLE: if (convert_in) begin
				// Fall starts it; with stay_up_in the pin rises after ACQ_GAP_CYCLES so an auto-down device stays up
				cs_next = 1'b0;
				cnt_next = '0;
				up_next = stay_up_in;
				st_next = HS_LOW;
			end
			HS_LOW: begin
				cnt_next = cnt_reg + 1'b1;
				if (up_reg && cnt_reg == CNT_W'(ACQ_GAP_CYCLES))
					cs_next = 1'b1;
				if (cnt_reg == CNT_W'(WAKE_CYCLES + CONV_CYCLES + 8)) begin
					cs_next = 1'b1;
					fs_next = 1'b1;
					edge_next = '0;
					st_next = HS_READ;
				end
			end
			HS_READ: if (tick) begin
				ck_next = ~ck_reg;
				if (!ck_reg) begin
					edge_next = edge_reg + 5'h1;
				end else if (edge_reg >= 5'h1 && edge_reg <= 5'(RESULT_W)) begin
					// Bits taken on the falls after rises one to ten; rise eleven only releases
					sh_next = {sh_reg[RESULT_W-2:0], din_sync_reg[1]};
				end
				if (ck_reg && edge_reg == 5'(RESULT_W + 1)) begin
					fs_next = 1'b0;
					dat_next = sh_reg;
					dv_next = 1'b1;
					cnt_next = '0;
					st_next = HS_WAIT;
				end
			end
			HS_WAIT: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(ACQ_GAP_CYCLES))
					st_next = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_reg <= HS_IDLE;  cnt_reg <= '0;  div_reg <= 4'h0;  edge_reg <= 5'h0;
			cs_reg <= 1'b1;  fs_reg <= 1'b0;  ck_reg <= 1'b0;
			ps_reg <= PSEL_RESET;  er_reg <= 1'b0;  wr_reg <= 1'b0;
			sh_reg <= '0;  dat_reg <= '0;  dv_reg <= 1'b0;  up_reg <= 1'b0;
			din_sync_reg <= 2'h0;
			busy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;  cnt_reg <= cnt_next;  div_reg <= div_next;
			edge_reg <= edge_next;
			cs_reg <= cs_next;  fs_reg <= fs_next;  ck_reg <= ck_next;
			ps_reg <= ps_next;  er_reg <= er_next;  wr_reg <= wr_next;
			sh_reg <= sh_next;  dat_reg <= dat_next;  dv_reg <= dv_next;
			up_reg <= up_next;
			din_sync_reg <= {din_sync_reg[0], link.dout};
			busy_reg <= (st_next != HS_IDLE);
		end
	end

	assign link.conv_start_n  = cs_reg;
	assign link.rx_frame_sync = fs_reg;
	assign link.sclk          = ck_reg;
	assign link.power_sel     = ps_reg;
	assign link.ext_ref_sel   = er_reg;
	assign link.power_sel_wr  = wr_reg;
	assign busy_out           = busy_reg;
	assign data_valid_out     = dv_reg;
	assign data_out           = dat_reg;
endmodule

// ==== adc_pwr_seq_asserts.sv ====
// Wire-level assertions on the link between host and converter ends
`timescale 1ns/10ps
module adc_pwr_seq_asserts
	import adc_pwr_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       reset_in,
	input  wire logic       conv_start_n,
	input  wire logic       rx_frame_sync,
	input  wire logic       sclk,
	input  wire logic       dout,
	input  wire logic       dout_oe,
	input  wire logic [1:0] power_sel,
	input  wire logic       ext_ref_sel,
	input  wire logic       power_sel_wr
);
	// Ten serial clock periods of SCLK_DIV high and SCLK_DIV low
	localparam int OE_CYCLES = 20 * SCLK_DIV;

	logic       up_seen_reg;
	logic       up_seen_next;
	logic [7:0] gap_reg;
	logic [7:0] gap_next;
	logic [8:0] oe_cnt_reg;
	logic [8:0] oe_cnt_next;

	// Gap saturates so an idle link never wraps back below the limit
	always_comb begin
		up_seen_next = up_seen_reg | (power_sel_wr & (power_sel == PSEL_FULL_UP));
		gap_next     = (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h01;
		oe_cnt_next  = 9'h000;
		if (dout_oe) begin
			gap_next    = 8'h00;
			oe_cnt_next = oe_cnt_reg + 9'h001;
		end
		if (reset_in) begin
			up_seen_next = 1'b0;
			gap_next     = 8'hff;
			oe_cnt_next  = 9'h000;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		up_seen_reg <= up_seen_next;
		gap_reg     <= gap_next;
		oe_cnt_reg  <= oe_cnt_next;
	end

	reset_idle_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(reset_in) |-> conv_start_n && !rx_frame_sync && !dout_oe)
		else $error("link not idle after reset");
	up_first_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(conv_start_n) |-> up_seen_reg)
		else $error("conversion requested before full power-up");
	wr_pulse_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		power_sel_wr |=> !power_sel_wr)
		else $error("power field write longer than one cycle");
	oe_needs_fs_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(dout_oe) |-> rx_frame_sync && $past(rx_frame_sync, 2))
		else $error("data output enabled without frame sync");
	oe_on_sclk_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(dout_oe) |-> sclk)
		else $error("data output enabled away from a serial clock rise");
	dout_on_sclk_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$changed(dout) |-> sclk && !$past(sclk, 4))
		else $error("data changed outside serial clock high phase");
	oe_length_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(dout_oe) |-> oe_cnt_reg == 9'(OE_CYCLES) && rx_frame_sync)
		else $error("data output window not ten serial clocks");
	acq_gap_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$fell(conv_start_n) |-> !dout_oe && gap_reg >= 8'(ACQ_GAP_CYCLES))
		else $error("start pin fell too soon after a read");
endmodule

// ==== adc_power_conversion_sequencer_bench.sv ====
// Self-checking bench: host and converter ends joined over the link
`timescale 1ns/10ps
module adc_power_conversion_sequencer_bench;
	import adc_pwr_pkg::*;
	// Short reference warm-up keeps the run brief
	localparam int REF_SIM = 300;

	logic                clk_sys_in     = 1'b0;
	logic                reset_in       = 1'b1;
	logic [RESULT_W-1:0] sample_in      = 10'h000;
	logic [1:0]          power_sel_in   = 2'h0;
	logic                ext_ref_sel_in = 1'b0;
	logic                power_wr_in    = 1'b0;
	logic                convert_in     = 1'b0;
	logic                stay_up_in     = 1'b0;
	logic                powered_out;
	logic                ref_powered_out;
	logic                converting_out;
	logic [RESULT_W-1:0] result_out;
	logic                busy_out;
	logic                data_valid_out;
	logic [RESULT_W-1:0] data_out;
	logic                sclk_q         = 1'b0;
	logic                fs_q           = 1'b0;
	logic [9:0]          wire_word      = 10'h000;
	int                  wire_bits      = 0;
	int                  n_mismatch     = 0;
	int                  comparisons    = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	adc_link_if adc_link_if_i ();
	adc_pwr_seq #(.REF_CYCLES(REF_SIM)) adc_pwr_seq_i (.clk_sys_in(clk_sys_in),
		.reset_in(reset_in), .link(adc_link_if_i.device), .sample_in(sample_in),
		.powered_out(powered_out), .ref_powered_out(ref_powered_out),
		.converting_out(converting_out), .result_out(result_out));
	adc_host_ctrl adc_host_ctrl_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.link(adc_link_if_i.host), .power_sel_in(power_sel_in),
		.ext_ref_sel_in(ext_ref_sel_in), .power_wr_in(power_wr_in),
		.convert_in(convert_in), .stay_up_in(stay_up_in), .busy_out(busy_out),
		.data_valid_out(data_valid_out), .data_out(data_out));
	adc_pwr_seq_asserts adc_pwr_seq_asserts_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.conv_start_n(adc_link_if_i.conv_start_n), .rx_frame_sync(adc_link_if_i.rx_frame_sync),
		.sclk(adc_link_if_i.sclk), .dout(adc_link_if_i.dout), .dout_oe(adc_link_if_i.dout_oe),
		.power_sel(adc_link_if_i.power_sel), .ext_ref_sel(adc_link_if_i.ext_ref_sel),
		.power_sel_wr(adc_link_if_i.power_sel_wr));

	// Wire monitor: bits taken on serial clock falls, half a period after launch
	always @(posedge clk_sys_in) begin
		sclk_q <= adc_link_if_i.sclk;
		fs_q   <= adc_link_if_i.rx_frame_sync;
		if (adc_link_if_i.rx_frame_sync && !fs_q) begin
			wire_bits <= 0;
		end else if (sclk_q && !adc_link_if_i.sclk && adc_link_if_i.dout_oe) begin
			wire_word <= {wire_word[8:0], adc_link_if_i.dout};
			wire_bits <= wire_bits + 1;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic write_pwr(input logic [1:0] sel, input logic ext);
		power_sel_in   <= sel;
		ext_ref_sel_in <= ext;
		power_wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		power_wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	// Ends on a falling edge; caller checks, then realigns to a rising edge
	task automatic count_up(output int n);
		for (n = 0; n < 2000 && powered_out !== 1'b1; n++)
			@(negedge clk_sys_in);
		if (n >= 2000) begin
			check(16'h0001, 16'h0000);
			tally_and_finish();
		end
	endtask

	task automatic do_conv(input logic stay, input logic [9:0] code, input logic [9:0] exp_data,
			input int exp_len, output logic slept, output logic ref_asleep);
		int n;
		int len;
		slept      = 1'b0;
		ref_asleep = 1'b0;
		len        = 0;
		// The host drops a start request that arrives while it finishes a read
		for (n = 0; n < 100 && busy_out !== 1'b0; n++)
			@(posedge clk_sys_in);
		if (n >= 100) begin
			check(16'h0001, 16'h0000);
			tally_and_finish();
		end
		sample_in  <= code;
		stay_up_in <= stay;
		convert_in <= 1'b1;
		@(posedge clk_sys_in);
		convert_in <= 1'b0;
		for (n = 0; n < 3000 && data_valid_out !== 1'b1; n++) begin
			@(negedge clk_sys_in);
			if (converting_out === 1'b1)
				len++;
			if (len > 0 && powered_out === 1'b0 && !slept) begin
				slept      = 1'b1;
				ref_asleep = ref_powered_out;
			end
		end
		if (n >= 3000) begin
			check(16'h0001, 16'h0000);
			tally_and_finish();
		end
		check(16'(data_out), 16'(exp_data));
		check(16'(wire_word), 16'(exp_data));
		check(16'(wire_bits), 16'h000a);
		check(16'(len), 16'(exp_len));
		if (exp_len != 0)
			check(16'(result_out), 16'(code));
		@(posedge clk_sys_in);
	endtask

	task automatic t_cold();
		int n;
		@(negedge clk_sys_in);
		check(16'(powered_out), 16'h0000);
		@(posedge clk_sys_in);
		write_pwr(PSEL_FULL_UP, 1'b0);
		count_up(n);
		check(16'(n >= REF_SIM - 5 && n <= REF_SIM + 10), 16'h0001);
		check(16'(ref_powered_out), 16'h0001);
		@(posedge clk_sys_in);
		$display("cold start done");
	endtask

	task automatic t_mode1();
		logic s;
		logic r;
		do_conv(1'b1, 10'h2a5, 10'h2a5, CONV_CYCLES, s, r);
		check(16'(s), 16'h0000);
		// Field 11 ignores the pin even when it is left low
		do_conv(1'b0, 10'h15a, 10'h15a, CONV_CYCLES, s, r);
		check(16'(s), 16'h0000);
		$display("mode1 done");
	endtask

	task automatic t_auto(input logic [1:0] sel, input logic exp_ref);
		logic s;
		logic r;
		int   n;
		write_pwr(sel, 1'b0);
		do_conv(1'b0, 10'h3ff, 10'h3ff, CONV_CYCLES, s, r);
		check(16'(s), 16'h0001);
		check(16'(r), 16'(exp_ref));
		// Read ran during the wake its pin rise began; next start pin fall lands inside the wake
		do_conv(1'b0, 10'h001, 10'h001, CONV_CYCLES, s, r);
		check(16'(s), 16'h0001);
		count_up(n);
		check(16'(n <= WAKE_CYCLES + 10), 16'h0001);
		@(posedge clk_sys_in);
		$display("auto power-down done");
	endtask

	task automatic t_off();
		logic s;
		logic r;
		int   n;
		write_pwr(PSEL_FULL_DOWN, 1'b0);
		// The field lands one cycle before the state leaves idle
		@(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check(16'(powered_out), 16'h0000);
		check(16'(ref_powered_out), 16'h0000);
		@(posedge clk_sys_in);
		// No conversion while off; the port still returns the last result
		do_conv(1'b1, 10'h0f0, 10'h001, 0, s, r);
		write_pwr(PSEL_FULL_UP, 1'b1);
		count_up(n);
		check(16'(n <= WAKE_CYCLES + 5), 16'h0001);
		check(16'(ref_powered_out), 16'h0000);
		@(posedge clk_sys_in);
		do_conv(1'b1, 10'h0f0, 10'h0f0, CONV_CYCLES, s, r);
		$display("full power-down done");
	endtask

	// Start pin falls inside a cold wake; the read then overlaps the conversion end
	task automatic t_early();
		logic s;
		logic r;
		write_pwr(PSEL_FULL_DOWN, 1'b0);
		write_pwr(PSEL_FULL_UP, 1'b0);
		do_conv(1'b1, 10'h155, 10'h0f0, CONV_CYCLES, s, r);
		check(16'(s), 16'h0000);
		// Powered off, the port must return the result whose load was deferred
		write_pwr(PSEL_FULL_DOWN, 1'b0);
		do_conv(1'b1, 10'h3c3, 10'h155, 0, s, r);
		$display("early start done");
	endtask

	initial begin
		repeat (5) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		t_cold();
		t_mode1();
		t_auto(PSEL_AUTO_PART, 1'b1);
		t_auto(PSEL_AUTO_FULL, 1'b0);
		t_off();
		t_early();
		tally_and_finish();
	end
endmodule
